// file: hw/fbs_pkg.sv
// constants shared by the burst read sequencer, its fifo and its synchroniser
// assumes one clock (pclk) and an asynchronous active-low reset
package fbs_pkg;

   // register byte addresses
   localparam logic [11:0] ADDR_CFG    = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_CURPOS = 12'h008;

   // configuration register fields
   localparam int CFG_BL_LSB    = 0;
   localparam int CFG_BL_MSB    = 2;
   localparam int CFG_WRAP_BIT  = 3;
   localparam int CFG_RWF_BIT   = 4;
   localparam int CFG_EDGE_BIT  = 6;
   localparam int CFG_ASYNC_BIT = 15;
   localparam logic [31:0] CFG_RESET = 32'h0000_0057;
   localparam logic [31:0] CFG_WMASK = 32'h0000_805F;

   // burst length encodings
   localparam logic [2:0] BL_4    = 3'h1;
   localparam logic [2:0] BL_8    = 3'h2;
   localparam logic [2:0] BL_16   = 3'h3;
   localparam logic [2:0] BL_CONT = 3'h7;

   // status register fields
   localparam int ST_STATE_LSB  = 0;
   localparam int ST_WAITED_BIT = 8;
   localparam int ST_WAIT_BIT   = 9;
   localparam int ST_VALID_BIT  = 10;

   // word counts
   localparam logic [4:0] WORDS_4  = 5'h04;
   localparam logic [4:0] WORDS_8  = 5'h08;
   localparam logic [4:0] WORDS_16 = 5'h10;

   // index of the last edge, counted from zero, in the power-up latching sequence
   localparam logic [1:0] FALS_LAST_EDGE = 2'h2;

   // cycles the ready pin is held low after reset
   localparam int INIT_CYCLES_DEF = 16;

   typedef enum logic [3:0] {
      ST_INIT  = 4'b0001,
      ST_FALS  = 4'b0010,
      ST_IDLE  = 4'b0100,
      ST_BURST = 4'b1000
   } fbs_state_t;

endpackage

// file: hw/fbs_sync.sv
// two-flop synchroniser for a group of pin levels
// assumes the levels are quasi-static against pclk
`timescale 1ns/10ps
module fbs_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   import fbs_pkg::*;

   logic [W-1:0] meta_r;

   generate
      if (W < 1) begin : g_bad_w
         $error("fbs_sync: width must be at least 1");
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule

// file: hw/fbs_fifo.sv
// word fifo between array fetch and pin output
// assumes both sides run on the same clock; clr empties it at once
`timescale 1ns/10ps
module fbs_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         clr,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);
   import fbs_pkg::*;

   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_r [DEPTH];
   logic [AW:0]  wr_ptr_r;
   logic [AW:0]  rd_ptr_r;
   wire          full;
   wire          empty;
   wire          do_push;
   wire          do_pop;

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("fbs_fifo: depth must be a power of two, at least 2");
      end
   endgenerate

   assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
   assign empty     = (wr_ptr_r == rd_ptr_r);
   assign in_ready  = !full && !clr;
   assign out_valid = !empty && !clr;
   assign out_data  = mem_r[rd_ptr_r[AW-1:0]];
   assign do_push   = in_valid && in_ready;
   assign do_pop    = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem_r[wr_ptr_r[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else if (clr) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end

endmodule

// file: hw/fbs_burst_seq.sv
// read-path sequencer of a nor flash: asynchronous reads and synchronous bursts
// assumes flash pins arrive asynchronously; the array answers mem_addr in the same cycle
`timescale 1ns/10ps
module fbs_burst_seq #(
   parameter int AW          = 24,
   parameter int DW          = 16,
   parameter int FIFO_DEPTH  = 8,
   parameter int INIT_CYCLES = fbs_pkg::INIT_CYCLES_DEF
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          chip_en_n,
   input  wire logic          out_en_n,
   input  wire logic          latch_en_n,
   input  wire logic [AW-1:0] addr_pin,
   input  wire logic          rdy_wait_in,
   output logic               rdy_wait_out,
   output logic               rdy_wait_oe,
   output logic      [DW-1:0] dq_out,
   output logic               dq_oe,
   output logic      [AW-1:0] mem_addr,
   input  wire logic [DW-1:0] mem_rdata
);
   import fbs_pkg::*;

   generate
      if (AW < 5 || AW > 32 || DW < 1 || DW > 32) begin : g_bad_width
         $error("fbs_burst_seq: address width 5..32 and data width 1..32");
      end
      if (INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin : g_bad_init
         $error("fbs_burst_seq: init cycles must be 1..65535");
      end
   endgenerate

   localparam logic [15:0] INIT_LAST = 16'(INIT_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisation

   logic [AW+3:0] pin_s;
   wire           ce_n_s;
   wire           oe_n_s;
   wire           le_n_s;
   wire           rw_s;
   wire [AW-1:0]  addr_s;

   fbs_sync #(
      .W (AW + 4)
   ) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({chip_en_n, out_en_n, latch_en_n, rdy_wait_in, addr_pin}),
      .q     (pin_s)
   );

   assign ce_n_s = pin_s[AW+3];
   assign oe_n_s = pin_s[AW+2];
   assign le_n_s = pin_s[AW+1];
   assign rw_s   = pin_s[AW];
   assign addr_s = pin_s[AW-1:0];

   ////////////////////////////////////////////////////////////////////////////
   // configuration decode

   logic [31:0] cfg_r;
   wire  [2:0]  burst_length_field;
   wire         wrap_select_bit;
   wire         ready_wait_function_select;
   wire         active_edge_select;
   wire         mode_async;
   wire         cont;
   wire         use_wrap;
   wire  [4:0]  len_words;
   wire  [3:0]  wrap_mask;

   // mode and format follow only the live configuration register
   assign burst_length_field         = cfg_r[CFG_BL_MSB:CFG_BL_LSB];
   assign wrap_select_bit            = cfg_r[CFG_WRAP_BIT];
   assign ready_wait_function_select = cfg_r[CFG_RWF_BIT];
   assign active_edge_select         = cfg_r[CFG_EDGE_BIT];
   assign mode_async                 = cfg_r[CFG_ASYNC_BIT];
   assign cont = !(burst_length_field == BL_4 || burst_length_field == BL_8
                   || burst_length_field == BL_16);
   assign len_words = (burst_length_field == BL_4) ? WORDS_4 :
                      (burst_length_field == BL_8) ? WORDS_8 : WORDS_16;
   assign wrap_mask = 4'(len_words - 5'h01);
   // continuous bursts never wrap, whatever the wrap bit says
   assign use_wrap  = !wrap_select_bit && !cont;

   ////////////////////////////////////////////////////////////////////////////
   // state

   fbs_state_t     state_r;
   fbs_state_t     state_nxt;
   logic [15:0]    init_cnt_r;
   logic [1:0]     fals_cnt_r;
   logic           latched_r;
   logic           rw_low_r;
   logic [AW-1:0]  start_r;
   logic [AW-1:0]  fetch_addr_r;
   logic [4:0]     issued_r;
   logic [1:0]     wait_cnt_r;
   logic           waited_r;
   logic [DW-1:0]  dq_r;
   logic           dq_oe_r;
   logic           valid_r;

   wire fals_hit;
   wire in_burst;
   wire start_burst;
   wire fetch_done;
   wire fifo_in_valid;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire fifo_out_ready;
   wire [DW-1:0] fifo_out_data;
   wire push;
   wire pop;
   wire crossing;
   wire [AW-1:0] wrap_nxt;
   wire [AW-1:0] fetch_nxt;
   wire wait_act;

   // output and chip enable low, latch enable and ready high
   assign fals_hit = !oe_n_s && !ce_n_s && le_n_s && rw_s;
   assign in_burst = (state_r == ST_BURST);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_INIT: begin
            if (init_cnt_r == INIT_LAST) begin
               state_nxt = ST_FALS;
            end
         end
         ST_FALS: begin
            if (fals_hit && fals_cnt_r == FALS_LAST_EDGE) begin
               state_nxt = ST_BURST;
            end
         end
         ST_IDLE: begin
            if (!mode_async && latched_r && !ce_n_s && le_n_s) begin
               state_nxt = ST_BURST;
            end else if (ready_wait_function_select && rw_low_r && rw_s) begin
               state_nxt = ST_FALS;
            end
         end
         ST_BURST: begin
            if (ce_n_s || !le_n_s) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_INIT;
         end
      endcase
   end

   assign start_burst = (state_nxt == ST_BURST) && !in_burst;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r    <= ST_INIT;
         init_cnt_r <= 16'h0000;
         fals_cnt_r <= 2'h0;
      end else begin
         state_r    <= state_nxt;
         init_cnt_r <= (state_r == ST_INIT) ? init_cnt_r + 16'h0001 : 16'h0000;
         if (state_r != ST_FALS) begin
            fals_cnt_r <= 2'h0;
         end else if (fals_hit) begin
            fals_cnt_r <= fals_cnt_r + 2'h1;
         end
      end
   end

   // address capture while latch and chip enable are low in idle, or at the last power-up latching edge; ready pulse retrigger
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_r   <= '0;
         latched_r <= 1'b0;
         rw_low_r  <= 1'b0;
      end else begin
         if (state_r == ST_FALS && fals_hit && fals_cnt_r == FALS_LAST_EDGE) begin
            start_r <= addr_s;
         end else if (state_r == ST_IDLE && !ce_n_s && !le_n_s) begin
            start_r <= addr_s;
         end
         if (start_burst) begin
            latched_r <= 1'b0;
         end else if (state_r == ST_IDLE && !ce_n_s && !le_n_s) begin
            latched_r <= 1'b1;
         end
         if (state_r != ST_IDLE) begin
            rw_low_r <= 1'b0;
         end else if (!rw_s) begin
            rw_low_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // burst address generation

   // any bank, any address: no bank is limited to one read style
   assign mem_addr   = mode_async ? addr_s : fetch_addr_r;
   assign fetch_done = !cont && (issued_r == len_words);
   assign fifo_in_valid = in_burst && !fetch_done && (wait_cnt_r == 2'h0);
   assign push       = fifo_in_valid && fifo_in_ready;
   assign wrap_nxt   = {fetch_addr_r[AW-1:4],
                        (fetch_addr_r[3:0] & ~wrap_mask) |
                        ((fetch_addr_r[3:0] + 4'h1) & wrap_mask)};
   assign fetch_nxt  = use_wrap ? wrap_nxt : fetch_addr_r + 1'b1;
   // offset from a four-word boundary costs that many cycles, once only
   assign crossing   = !use_wrap && !waited_r && (fetch_addr_r[3:0] == 4'hF)
                       && (start_r[1:0] != 2'h0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch_addr_r <= '0;
         issued_r     <= 5'h00;
         wait_cnt_r   <= 2'h0;
         waited_r     <= 1'b0;
      end else if (start_burst) begin
         fetch_addr_r <= (state_r == ST_FALS) ? addr_s : start_r;
         issued_r     <= 5'h00;
         wait_cnt_r   <= 2'h0;
         waited_r     <= 1'b0;
      end else if (in_burst) begin
         if (wait_cnt_r != 2'h0) begin
            wait_cnt_r <= wait_cnt_r - 2'h1;
         end else if (push) begin
            fetch_addr_r <= fetch_nxt;
            issued_r     <= cont ? issued_r : issued_r + 5'h01;
            if (crossing) begin
               wait_cnt_r <= start_r[1:0];
               waited_r   <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // word buffer and pin output

   // a stalled output (output enable high) suspends the burst in place
   fbs_fifo #(
      .W     (DW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (pclk),
      .rst_n     (presetn),
      .clr       (!in_burst),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (mem_rdata),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   assign fifo_out_ready = in_burst && !oe_n_s;
   assign pop            = fifo_out_valid && fifo_out_ready;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dq_r    <= '0;
         dq_oe_r <= 1'b0;
         valid_r <= 1'b0;
      end else begin
         dq_oe_r <= !ce_n_s && !oe_n_s;
         valid_r <= !mode_async && pop;
         if (mode_async) begin
            dq_r <= mem_rdata;
         end else if (pop) begin
            dq_r <= fifo_out_data;
         end
      end
   end

   // wait is shown while data is not valid; never in asynchronous mode
   assign wait_act     = !mode_async && !oe_n_s && !valid_r;
   assign rdy_wait_oe  = (state_r == ST_INIT) || (!ready_wait_function_select && !ce_n_s);
   assign rdy_wait_out = (state_r == ST_INIT) ? 1'b0 : !wait_act;
   assign dq_out       = dq_r;
   assign dq_oe        = dq_oe_r;

   ////////////////////////////////////////////////////////////////////////////
   // apb slave

   logic [31:0] prdata_r;
   wire         hit_cfg;
   wire         hit_status;
   wire         hit_curpos;
   wire         hit_any;
   wire         wr_cfg;
   wire  [31:0] status_word;
   wire  [31:0] curpos_word;
   wire  [31:0] rd_mux;

   assign hit_cfg     = (paddr == ADDR_CFG);
   assign hit_status  = (paddr == ADDR_STATUS);
   assign hit_curpos  = (paddr == ADDR_CURPOS);
   assign hit_any     = hit_cfg || hit_status || hit_curpos;
   assign wr_cfg      = psel && penable && pwrite && hit_cfg;
   assign status_word = (32'(state_r) << ST_STATE_LSB) |
                        (32'(waited_r) << ST_WAITED_BIT) |
                        (32'(wait_act) << ST_WAIT_BIT) |
                        (32'(valid_r) << ST_VALID_BIT);
   assign curpos_word = 32'(fetch_addr_r);
   assign rd_mux      = hit_cfg    ? cfg_r :
                        hit_status ? status_word :
                        hit_curpos ? curpos_word : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r    <= CFG_RESET;
         prdata_r <= 32'h0000_0000;
      end else begin
         if (wr_cfg) begin
            cfg_r <= pwdata & CFG_WMASK;
         end
         if (psel && !penable) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   assign prdata  = prdata_r;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !hit_any;

endmodule

// file: dv/fbs_far_model.sv
// far side of the flash pins: array contents and the pulled-up ready wire
// assumes the array answers mem_addr combinationally, in the same cycle
`timescale 1ns/10ps
module fbs_far_model #(
   parameter int AW = 24,
   parameter int DW = 16
) (
   input  wire logic [AW-1:0] mem_addr,
   output logic      [DW-1:0] mem_rdata,
   input  wire logic          rdy_wait_out,
   input  wire logic          rdy_wait_oe,
   output logic               rdy_wait_in
);
   // bank bits fold into the word so every bank reads distinct data
   assign mem_rdata   = mem_addr[15:0] ^ {mem_addr[23:16], 8'hC3};
   // released wire floats high through the pull-up
   assign rdy_wait_in = rdy_wait_oe ? rdy_wait_out : 1'b1;
endmodule

// file: dv/fbs_burst_seq_chk.sv
// concurrent checks on the ports of the burst read sequencer
// assumes an apb master that keeps setup and access phases in order
`timescale 1ns/10ps
module fbs_burst_seq_chk
   import fbs_pkg::*;
#(
   parameter int AW          = 24,
   parameter int DW          = 16,
   parameter int INIT_CYCLES = 16
) (
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [11:0]   paddr,
   input wire logic [31:0]   pwdata,
   input wire logic [31:0]   prdata,
   input wire logic          pready,
   input wire logic          pslverr,
   input wire logic          rdy_wait_out,
   input wire logic          rdy_wait_oe,
   input wire logic [DW-1:0] dq_out,
   input wire logic [AW-1:0] addr_pin,
   input wire logic [AW-1:0] mem_addr,
   input wire logic [DW-1:0] mem_rdata
);
   logic [7:0]  cnt_r;
   logic [31:0] cfg_r;
   wire         acc   = psel && penable;
   wire         unmap = (paddr != ADDR_CFG) && (paddr != ADDR_STATUS) && (paddr != ADDR_CURPOS);
   wire         asy   = cfg_r[CFG_ASYNC_BIT] && !cfg_r[CFG_RWF_BIT];
   ////////////////////////////////////////////////////////////////////////////
   // shadow of the configuration register and cycles since reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 8'h00;
         cfg_r <= CFG_RESET;
      end else begin
         if (cnt_r != 8'hFF) cnt_r <= cnt_r + 8'h01;
         if (acc && pwrite && (paddr == ADDR_CFG)) cfg_r <= pwdata & CFG_WMASK;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////
   a_init_ready_low: assert property (int'(cnt_r) < INIT_CYCLES - 1 |->
      rdy_wait_oe && !rdy_wait_out)
      else $error("ready wire not held low after reset");
   a_ready_release: assert property (int'(cnt_r) == INIT_CYCLES + 4 |-> !rdy_wait_oe)
      else $error("ready wire not released");
   a_unmapped_err: assert property (acc && unmap |-> pslverr && (prdata == 32'h0000_0000))
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (acc && !unmap |-> !pslverr)
      else $error("mapped access refused");
   a_pready_high: assert property (psel |-> pready)
      else $error("apb wait state seen");
   a_async_no_wait: assert property (asy |-> !(rdy_wait_oe && !rdy_wait_out))
      else $error("wait asserted in asynchronous mode");
   a_async_data: assert property (asy && $past(asy) |-> dq_out == $past(mem_rdata))
      else $error("asynchronous data does not follow the array");
   a_async_addr: assert property (asy && cnt_r > 8'h03 |-> mem_addr == $past(addr_pin, 2))
      else $error("asynchronous address does not follow the pins");
   c_apb_err: cover property (acc && pslverr);
   c_async: cover property (asy && $past(asy));
   c_wait: cover property (!asy && rdy_wait_oe && !rdy_wait_out && cnt_r == 8'hFF);
endmodule
bind fbs_burst_seq fbs_burst_seq_chk #(.AW(AW), .DW(DW), .INIT_CYCLES(INIT_CYCLES)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .rdy_wait_out(rdy_wait_out), .rdy_wait_oe(rdy_wait_oe), .dq_out(dq_out),
   .addr_pin(addr_pin), .mem_addr(mem_addr), .mem_rdata(mem_rdata));

// file: dv/fbs_burst_seq_tb_top.sv
// self-checking bench: apb registers, power-up latching, bursts, async reads
// assumes the far-side model answers array reads in the same cycle
`timescale 1ns/10ps
module fbs_burst_seq_tb_top;
   import fbs_pkg::*;
   localparam int AW = 24;
   localparam int DW = 16;
   logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0]   paddr = 12'h000;
   logic [31:0]   pwdata = 32'h0000_0000, prdata, seed = 32'h0000_2E81;
   logic          pready, pslverr, rdy_wait_in, rdy_wait_out, rdy_wait_oe, dq_oe;
   logic          chip_en_n = 1, out_en_n = 1, latch_en_n = 1, capt = 0;
   logic [AW-1:0] addr_pin = 24'h000000, mem_addr;
   logic [DW-1:0] dq_out, mem_rdata;
   logic [23:0]   expq[$];
   int            error_cnt = 0, checks = 0, wcnt = 0;
   always #10 pclk = ~pclk;
   fbs_burst_seq i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chip_en_n(chip_en_n), .out_en_n(out_en_n), .latch_en_n(latch_en_n),
      .addr_pin(addr_pin), .rdy_wait_in(rdy_wait_in), .rdy_wait_out(rdy_wait_out),
      .rdy_wait_oe(rdy_wait_oe), .dq_out(dq_out), .dq_oe(dq_oe), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata));
   fbs_far_model #(.AW(AW), .DW(DW)) i_far (.mem_addr(mem_addr), .mem_rdata(mem_rdata),
      .rdy_wait_out(rdy_wait_out), .rdy_wait_oe(rdy_wait_oe), .rdy_wait_in(rdy_wait_in));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [DW-1:0] mdat(input logic [AW-1:0] a);
      return a[15:0] ^ {a[23:16], 8'hC3};
   endfunction
   task automatic fail(input string m);
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
      checks++;
      if (g !== e) fail(m);
   endtask
   task automatic test_done();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 0; penable <= 0;
      // idle edge so a following call never reassigns psel in this time step
      @(posedge pclk);
   endtask
   task automatic state_is(input logic [3:0] s);
      logic [31:0] rd;
      logic er;
      apb(0, ADDR_STATUS, 32'h0, rd, er);
      cmp({28'h0, rd[3:0]}, {28'h0, s}, "state");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // one burst: expectations queued, pins driven, monitor compares
   task automatic burst(input logic [2:0] bl, input logic nw, input logic [AW-1:0] st);
      logic [31:0] rd;
      logic er, wr, hit;
      logic [AW-1:0] a;
      int len, i;
      len = (bl == BL_4) ? 4 : (bl == BL_8) ? 8 : (bl == BL_16) ? 16 : 20;
      wr = !nw && len != 20;
      hit = 0;
      apb(1, ADDR_CFG, 32'h0000_0040 | {28'h0, nw, bl}, rd, er);
      for (i = 0; i < len; i++) begin
         a = wr ? ((st & ~(len - 1)) | ((st + i) & (len - 1))) : st + i;
         if (i == 0) expq.push_back({8'hFF, mdat(a)});
         else if (!wr && a[3:0] == 4'h0 && !hit) begin
            expq.push_back({6'h0, st[1:0], mdat(a)});
            hit = 1;
         end else expq.push_back({8'h00, mdat(a)});
      end
      chip_en_n <= 0; out_en_n <= 0; latch_en_n <= 0; addr_pin <= st;
      repeat (6) @(posedge pclk);
      latch_en_n <= 1; capt <= 1;
      for (i = 0; i < 200 && expq.size() > 0; i++) @(posedge pclk);
      // a continuous burst keeps running: stop watching once all notes are taken
      if (len == 20) capt <= 0;
      repeat (3) @(posedge pclk);
      if (len != 20) cmp({31'h0, rdy_wait_out}, 32'h0, "end wait");
      capt <= 0; chip_en_n <= 1; out_en_n <= 1;
      repeat (4) @(posedge pclk);
      if (expq.size() != 0) fail("words missing");
      expq.delete();
   endtask
   always @(negedge pclk) begin
      if (capt && rdy_wait_oe === 1'b1) begin
         if (rdy_wait_out === 1'b0) wcnt++;
         else if (expq.size() > 0) begin
            checks++;
            if (dq_out !== expq[0][15:0] || dq_oe !== 1'b1) fail("burst word");
            if (expq[0][23:16] != 8'hFF && wcnt != expq[0][23:16]) fail("wait count");
            void'(expq.pop_front());
            wcnt = 0;
         end else fail("extra word");
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      fail("timeout");
      test_done();
   end
   initial begin
      logic [31:0] rd;
      logic er;
      logic [AW-1:0] a;
      int i;
      repeat (16) @(posedge pclk);
      presetn <= 1;
      repeat (22) @(posedge pclk);
      apb(0, ADDR_CFG, 32'h0, rd, er);
      cmp(rd, CFG_RESET, "cfg reset");
      state_is(ST_FALS);
      chip_en_n <= 0; out_en_n <= 0; latch_en_n <= 0; addr_pin <= 24'h00000D;
      repeat (10) @(posedge pclk);
      state_is(ST_FALS);
      latch_en_n <= 1;
      for (i = 0; i < 50 && rdy_wait_in !== 1'b1; i++) @(posedge pclk);
      repeat (10) @(posedge pclk);
      state_is(ST_BURST);
      chip_en_n <= 1; out_en_n <= 1;
      repeat (6) @(posedge pclk);
      state_is(ST_IDLE);
      apb(0, 12'h00C, 32'h0, rd, er);
      cmp({31'h0, er}, 32'h1, "unmapped");
      cmp(rd, 32'h0, "unmapped data");
      apb(0, 12'h002, 32'h0, rd, er);
      cmp({31'h0, er}, 32'h1, "misaligned");
      cmp(rd, 32'h0, "misaligned data");
      apb(1, ADDR_STATUS, 32'hFFFF_FFFF, rd, er);
      state_is(ST_IDLE);
      apb(1, ADDR_CFG, 32'hFFFF_FFFF, rd, er);
      apb(0, ADDR_CFG, 32'h0, rd, er);
      cmp(rd, CFG_WMASK, "cfg mask");
      burst(BL_4, 0, 24'h000007);
      burst(BL_16, 0, 24'h00000F);
      burst(BL_8, 1, 24'h00000D);
      burst(BL_16, 1, 24'h000003);
      burst(BL_CONT, 0, 24'h00000E);
      burst(BL_CONT, 1, 24'h00000E);
      burst(BL_CONT, 1, 24'h00000C);
      for (i = 0; i < 3; i++) burst(BL_CONT, rnd() & 1, rnd() & 24'hFFFF0F);
      apb(1, ADDR_CFG, 32'h0000_8040, rd, er);
      chip_en_n <= 0; out_en_n <= 0;
      for (i = 0; i < 4; i++) begin
         a = rnd();
         addr_pin <= a;
         repeat (4) @(posedge pclk);
         cmp({16'h0, dq_out}, {16'h0, mdat(a)}, "async data");
      end
      apb(1, ADDR_CFG, 32'h0000_0047, rd, er);
      burst(BL_CONT, 1, 24'h000001);
      test_done();
   end
endmodule
